/* File: hw/exv_core.sv */
/*
 * Exception vector and priority unit: pending and active state per
 * exception, priority arbitration, preemption and handler fetch address.
 * Assumes requests and the register port are synchronous to clk_i, and
 * that the core signals handler completion with a return pulse.
 */
//
// Summary of operation
// - IRQ n is exception n plus sixteen
// - Programmable priorities reset to zero
// - Table base is zero after reset
// - Only privileged in-range writes relocate base
// - Smaller value wins; two priorities fixed
// - Programmable priorities limited to 0 to 7
// - Ties go to the smallest exception number
// - Strictly more urgent exception preempts handler
// - Equal priority stays pending, no preemption
// - NMI always enabled at priority minus two
// - Hard fault fixed at priority minus one
// - Track inactive, pending, active, active-pending
`timescale 1ns/1ns
`default_nettype none

module exv_core (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] sys_req_i,
  input wire logic [43:0] irq_req_i,
  input wire logic ret_i,
  input wire logic [5:0] ret_num_i,
  input wire logic priv_i,
  input wire logic [9:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic take_o,
  output logic [5:0] take_num_o,
  output logic [31:0] fetch_addr_o,
  output logic [3:0] run_prio_o,
  output logic irq_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0] vtor;
    logic [59:0][2:0] prio;
    logic [59:0] pend;
    logic [59:0] act;
    logic [1:0] evt;
    logic [1:0] evt_en;
    logic [31:0] rdata;
    logic take;
    logic [5:0] take_num;
    logic [31:0] fetch;
    logic [3:0] run_prio;
    logic irq;
  } exv_state_t;

  exv_state_t s;
  exv_state_t next_s;

  logic [59:0][3:0] eff;
  logic [59:0] req;
  logic [59:0] pset;
  logic win_found;
  logic [5:0] win_num;
  logic [3:0] win_prio;
  logic run_found;
  logic [3:0] run_prio;
  logic [9:0] prio_ofs;
  logic [5:0] prio_idx;
  logic prio_hit;
  logic vtor_ok;
  logic take_ok;

  // ************************************************************
  // Effective priorities
  // ************************************************************

  // Fixed levels for NMI and hard fault, programmable ones shifted above.
  genvar g;
  generate
    for (g = 0; g < exv_pkg::NUM_EXC; g++) begin : g_eff
      if (g == exv_pkg::EXC_NMI) begin : g_nmi
        assign eff[g] = exv_pkg::EFF_NMI;
      end else if (g == exv_pkg::EXC_HARD) begin : g_hard
        assign eff[g] = exv_pkg::EFF_HARD;
      end else begin : g_cfg
        assign eff[g] = {1'b0, s.prio[g]} + exv_pkg::EFF_OFS;
      end
    end
  endgenerate

  // ************************************************************
  // Arbitration
  // ************************************************************

  // Highest pending exception, recomputed from the present state.
  exv_arbiter u_pend_arb (
    .cand_i(s.pend & exv_pkg::SRC_MASK),
    .prio_i(eff),
    .found_o(win_found),
    .num_o(win_num),
    .prio_o(win_prio)
  );

  // The running priority is the most urgent of all active handlers.
  exv_arbiter u_act_arb (
    .cand_i(s.act),
    .prio_i(eff),
    .found_o(run_found),
    .num_o(),
    .prio_o(run_prio)
  );

  // ************************************************************
  // Decode
  // ************************************************************

  // Requests map IRQ n onto exception number n plus sixteen.
  assign req = ({irq_req_i, sys_req_i} | pset) & exv_pkg::SRC_MASK;

  // Software pend-set words, taken only when strobed.
  assign pset[31:0] = (wr_i && addr_i == exv_pkg::REG_PSET_LO)
                      ? wdata_i : 32'h0000_0000;
  assign pset[59:32] = (wr_i && addr_i == exv_pkg::REG_PSET_HI)
                       ? wdata_i[27:0] : 28'h0000000;

  // Priority registers sit one per word from the base.
  assign prio_ofs = addr_i - exv_pkg::REG_PRIO_BASE;
  assign prio_idx = prio_ofs[7:2];
  assign prio_hit = addr_i >= exv_pkg::REG_PRIO_BASE &&
                    addr_i < exv_pkg::REG_PRIO_END && prio_ofs[1:0] == 2'h0;

  // A relocation is kept only when privileged, aligned and in range.
  assign vtor_ok = priv_i && (wdata_i & exv_pkg::VTOR_ALIGN) == 32'h0 &&
                   wdata_i >= exv_pkg::VTOR_MIN &&
                   wdata_i <= exv_pkg::VTOR_MAX;

  // Entry only when strictly more urgent than every active handler.
  assign take_ok = win_found && win_prio < run_prio;

  // ************************************************************
  // Next state
  // ************************************************************

  // Register writes, handler entry and return, and event capture.
  always_comb begin
    next_s = s;
    next_s.take = 1'b0;
    next_s.rdata = 32'h0000_0000;
    // Register writes.
    if (wr_i) begin
      if (addr_i == exv_pkg::REG_VTOR) begin
        if (vtor_ok) begin
          next_s.vtor = wdata_i;
        end
      end else if (addr_i == exv_pkg::REG_EVT_EN) begin
        next_s.evt_en = wdata_i[1:0];
      end else if (prio_hit && priv_i &&
                   exv_pkg::CFG_MASK[prio_idx]) begin
        next_s.prio[prio_idx] = wdata_i[2:0];
      end
    end
    // Event clear comes first so that a new event in the same cycle wins.
    if (wr_i && addr_i == exv_pkg::REG_EVT_CLR) begin
      next_s.evt = s.evt & ~wdata_i[1:0];
    end
    if (wr_i && addr_i == exv_pkg::REG_VTOR && !vtor_ok) begin
      next_s.evt[exv_pkg::EVT_REFUSED] = 1'b1;
    end
    if ((req & s.pend) != 60'h0) begin
      next_s.evt[exv_pkg::EVT_MERGED] = 1'b1;
    end
    // Handler completion clears the active bit.
    if (ret_i) begin
      next_s.act[ret_num_i] = 1'b0;
    end
    // Entry moves the winner from pending to active.
    if (take_ok) begin
      next_s.pend[win_num] = 1'b0;
      next_s.act[win_num] = 1'b1;
      next_s.take = 1'b1;
      next_s.take_num = win_num;
      next_s.fetch = s.vtor + {24'h000000, win_num, 2'h0};
    end
    // New requests set pending last, so a request never gets lost.
    next_s.pend = next_s.pend | req;
    next_s.run_prio = run_found ? run_prio : exv_pkg::EFF_IDLE;
    next_s.irq = (next_s.evt & next_s.evt_en) != 2'h0;
    // Read data stand in the following cycle only.
    if (rd_i) begin
      unique case (addr_i)
        exv_pkg::REG_VTOR: next_s.rdata = s.vtor;
        exv_pkg::REG_RUN: next_s.rdata = {21'h000000, win_found,
                                          win_num, s.run_prio};
        exv_pkg::REG_EVT_STAT: next_s.rdata = {30'h00000000, s.evt};
        exv_pkg::REG_EVT_EN: next_s.rdata = {30'h00000000, s.evt_en};
        exv_pkg::REG_PEND_LO: next_s.rdata = s.pend[31:0];
        exv_pkg::REG_PEND_HI: next_s.rdata = {4'h0, s.pend[59:32]};
        exv_pkg::REG_ACT_LO: next_s.rdata = s.act[31:0];
        exv_pkg::REG_ACT_HI: next_s.rdata = {4'h0, s.act[59:32]};
        default: begin
          if (prio_hit) begin
            next_s.rdata = {29'h00000000, s.prio[prio_idx]};
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************

  // Reset puts the table at zero and every priority at zero.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
      s.vtor <= exv_pkg::VTOR_RESET;
      s.prio <= {exv_pkg::NUM_EXC{exv_pkg::PRIO_RESET}};
      s.run_prio <= exv_pkg::EFF_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Every output is a field of the state register.
  assign rdata_o = s.rdata;
  assign take_o = s.take;
  assign take_num_o = s.take_num;
  assign fetch_addr_o = s.fetch;
  assign run_prio_o = s.run_prio;
  assign irq_o = s.irq;

endmodule : exv_core

`default_nettype wire

/* File: hw/exv_pkg.sv */
/*
 * Constants of the exception vector and priority unit: exception numbering,
 * priority encodings, register offsets and reset values.
 * Assumes nothing of its surroundings; it is compiled before every module.
 */
package exv_pkg;

  // ************************************************************
  // Exception numbering
  // ************************************************************
  localparam int NUM_EXC = 60;
  localparam int NUM_SYS = 16;
  localparam int NUM_IRQ = 44;
  localparam int NUM_W = 6;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  // Implemented exception sources; reserved numbers stay idle.
  localparam logic [59:0] SRC_MASK = 60'h807_f3ff_cfff_d87c;
  // Sources whose priority software may program.
  localparam logic [59:0] CFG_MASK = 60'h807_f3ff_cfff_d870;

  // ************************************************************
  // Priority encodings
  // ************************************************************
  localparam int PRIO_W = 3;
  localparam int EFF_W = 4;
  localparam logic [2:0] PRIO_RESET = 3'h0;
  // Effective priority is the printed value plus three, so -2 becomes 1.
  localparam logic [3:0] EFF_NMI = 4'h1;
  localparam logic [3:0] EFF_HARD = 4'h2;
  localparam logic [3:0] EFF_OFS = 4'h3;
  localparam logic [3:0] EFF_IDLE = 4'hf;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] REG_VTOR = 10'h000;
  localparam logic [9:0] REG_RUN = 10'h004;
  localparam logic [9:0] REG_EVT_STAT = 10'h008;
  localparam logic [9:0] REG_EVT_CLR = 10'h00c;
  localparam logic [9:0] REG_EVT_EN = 10'h010;
  localparam logic [9:0] REG_PEND_LO = 10'h014;
  localparam logic [9:0] REG_PEND_HI = 10'h018;
  localparam logic [9:0] REG_ACT_LO = 10'h01c;
  localparam logic [9:0] REG_ACT_HI = 10'h020;
  localparam logic [9:0] REG_PSET_LO = 10'h024;
  localparam logic [9:0] REG_PSET_HI = 10'h028;
  localparam logic [9:0] REG_PRIO_BASE = 10'h100;
  localparam logic [9:0] REG_PRIO_END = 10'h1f0;

  // ************************************************************
  // Vector table base
  // ************************************************************
  localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
  localparam logic [31:0] VTOR_MIN = 32'h0000_0100;
  localparam logic [31:0] VTOR_MAX = 32'h3fff_ff00;
  localparam logic [31:0] VTOR_ALIGN = 32'h0000_00ff;

  // ************************************************************
  // Event bits
  // ************************************************************
  localparam int EVT_W = 2;
  localparam int EVT_REFUSED = 0;
  localparam int EVT_MERGED = 1;

endpackage : exv_pkg

/* File: hw/exv_arbiter.sv */
/*
 * Combinational priority picker: finds the candidate with the smallest
 * effective priority value, lowest exception number on a tie.
 * Assumes the caller registers whatever it needs from the result.
 */
`timescale 1ns/1ns
`default_nettype none

module exv_arbiter (
  input wire logic [59:0] cand_i,
  input wire logic [59:0][3:0] prio_i,
  output logic found_o,
  output logic [5:0] num_o,
  output logic [3:0] prio_o
);

  // ************************************************************
  // Search
  // ************************************************************

  // Strict less-than keeps the earliest, so the lowest number wins ties.
  always_comb begin
    found_o = 1'b0;
    num_o = 6'h00;
    prio_o = exv_pkg::EFF_IDLE;
    for (int i = 0; i < exv_pkg::NUM_EXC; i++) begin
      if (cand_i[i] && (!found_o || prio_i[i] < prio_o)) begin
        found_o = 1'b1;
        num_o = 6'(i);
        prio_o = prio_i[i];
      end
    end
  end

endmodule : exv_arbiter

`default_nettype wire

/* File: dv/exv_core_asserts.sv */
/* Port checks of the exception vector and priority unit.
   Assumes it is bound to exv_core and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none

module exv_core_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] sys_req_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic take_o,
  input wire logic [5:0] take_num_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic [3:0] run_prio_o
);
  // Every check uses the one clock and is quiet during reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_nmi_entry;
    take_o && take_num_o == 6'h02;
  endsequence
  property p_fetch;
    take_o |-> fetch_addr_o[7:0] == {take_num_o, 2'b00};
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("Fetch offset does not match the number.");
  property p_rd;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("Read data outside its cycle.");
  property p_src;
    take_o |-> exv_pkg::SRC_MASK[take_num_o];
  endproperty
  a_src: assert property (p_src)
    else $error("Entry to a reserved number.");
  property p_nmi;
    sys_req_i[2] && run_prio_o == 4'hf |-> ##2 s_nmi_entry;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("Idle request of the non-maskable one not taken.");
  property p_nmi_run;
    s_nmi_entry |=> run_prio_o == 4'h1;
  endproperty
  a_nmi_run: assert property (p_nmi_run)
    else $error("Wrong running priority after the non-maskable one.");
  property p_hard_run;
    take_o && take_num_o == 6'h03 |=> run_prio_o == 4'h2;
  endproperty
  a_hard_run: assert property (p_hard_run)
    else $error("Wrong running priority after hard fault.");
  property p_preempt;
    take_o |=> run_prio_o < $past(run_prio_o);
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("Entry without strictly more urgent priority.");
  property p_hold;
    $changed(take_num_o) || $changed(fetch_addr_o) |-> take_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Entry outputs moved without an entry.");
endmodule : exv_core_chk

bind exv_core exv_core_chk i_exv_core_chk (.clk_i(clk_i),
  .reset_i(reset_i), .sys_req_i(sys_req_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .take_o(take_o), .take_num_o(take_num_o),
  .fetch_addr_o(fetch_addr_o), .run_prio_o(run_prio_o));

`default_nettype wire

/* File: dv/exv_core_model.sv */
/* Behavioural processor core that runs handlers and reports returns.
   Assumes entries arrive as one-cycle pulses on clk_i. */
`timescale 1ns/1ns
`default_nettype none

module exv_core_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic take_i,
  input wire logic [5:0] take_num_i,
  input wire logic [7:0] hold_i,
  output logic ret_o,
  output logic [5:0] ret_num_o
);
  logic [5:0] stack[$];
  logic [7:0] cnt;
  // Each handler runs hold_i cycles; the newest nested one returns first.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stack.delete();
      cnt <= 8'h00;
      ret_o <= 1'b0;
      ret_num_o <= 6'h00;
    end else begin
      ret_o <= 1'b0;
      ret_num_o <= ~ret_num_o; // Number is garbage outside a return.
      if (take_i) begin
        stack.push_back(take_num_i); // Handler word is odd code
        cnt <= hold_i;
      end else if (stack.size() != 0 && cnt == 8'h00) begin
        ret_o <= 1'b1;
        ret_num_o <= stack.pop_back();
        cnt <= hold_i;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : exv_core_model

`default_nettype wire

/* File: dv/test_exception_vector_priority.sv */
/* Self-checking bench of the exception vector and priority unit.
   Assumes exv_core, its package and the core model are compiled first. */
`timescale 1ns/1ns
`default_nettype none

module test_exception_vector_priority;
  logic clk_i = 1'b0;
  logic reset_i = 1'b0;
  logic [15:0] sys_req_i = '0;
  logic [43:0] irq_req_i = '0;
  logic ret_i;
  logic [5:0] ret_num_i;
  logic priv_i = 1'b0;
  logic [9:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic take_o;
  logic [5:0] take_num_o;
  logic [31:0] fetch_addr_o;
  logic [3:0] run_prio_o;
  logic irq_o;
  logic [7:0] hold = 8'h02;
  logic rd_d = 1'b0;
  logic [31:0] base;
  logic [37:0] q_tk[$];
  logic [31:0] q_rd[$];
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  exv_core i_exv_core (.clk_i(clk_i), .reset_i(reset_i),
    .sys_req_i(sys_req_i), .irq_req_i(irq_req_i), .ret_i(ret_i),
    .ret_num_i(ret_num_i), .priv_i(priv_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .take_o(take_o), .take_num_o(take_num_o), .irq_o(irq_o),
    .fetch_addr_o(fetch_addr_o), .run_prio_o(run_prio_o));
  exv_core_model i_exv_core_model (.clk_i(clk_i), .reset_i(reset_i),
    .take_i(take_o), .take_num_i(take_num_o), .hold_i(hold),
    .ret_o(ret_i), .ret_num_o(ret_num_i));

  // The clock toggles every 25 ns, a period of 50 ns.
  initial forever #25 clk_i = ~clk_i;

  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task wr(input logic [9:0] a, input logic [31:0] d, input logic p);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    priv_i <= p;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    q_rd.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd

  task pulse(input logic [59:0] m, input int wait_n);
    @(posedge clk_i);
    {irq_req_i, sys_req_i} <= m;
    @(posedge clk_i);
    {irq_req_i, sys_req_i} <= '0;
    repeat (wait_n) @(posedge clk_i);
  endtask : pulse

  function automatic logic [37:0] ent(input int x);
    return {6'(x), base + 32'(4 * x)};
  endfunction : ent

  function automatic logic [9:0] pa(input int x);
    return exv_pkg::REG_PRIO_BASE + 10'(4 * x);
  endfunction : pa

  // Watchers compare read data and entries against the oldest note.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    rd_d <= rd_i;
    if (rd_d) chk(rdata_o, q_rd.pop_front());
    if (take_o === 1'b1) chk({take_num_o, fetch_addr_o}, q_tk.pop_front());
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  // Main sequence: reset values, relocation, entries, nesting, reset.
  initial begin
    reset_i <= 1'b1;
    n = $urandom(17);
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(exv_pkg::REG_VTOR, 32'h0);
    rd(pa(16), 32'h0);
    rd(10'h3fc, 32'h0);
    wr(exv_pkg::REG_VTOR, 32'h0000_0200, 1'b0);
    wr(exv_pkg::REG_VTOR, 32'h0000_0210, 1'b1);
    wr(exv_pkg::REG_VTOR, 32'h4000_0000, 1'b1);
    wr(exv_pkg::REG_VTOR, 32'h0000_0000, 1'b1);
    rd(exv_pkg::REG_VTOR, 32'h0);
    chk(irq_o, 1'b0);
    rd(exv_pkg::REG_EVT_STAT, 32'h1);
    wr(exv_pkg::REG_EVT_EN, 32'h1, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wr(exv_pkg::REG_EVT_CLR, 32'h1, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wr(exv_pkg::REG_VTOR, exv_pkg::VTOR_MAX, 1'b1);
    rd(exv_pkg::REG_VTOR, exv_pkg::VTOR_MAX);
    base = $urandom_range(32'h3fffff, 1) << 8;
    wr(exv_pkg::REG_VTOR, base, 1'b1);
    rd(exv_pkg::REG_VTOR, base);
    q_tk.push_back(ent(2));
    pulse(60'h4, 8);
    for (int i = 0; i < 8; i++) begin
      n = $urandom_range(43, 0) + 16;
      if (exv_pkg::SRC_MASK[n]) begin
        q_tk.push_back(ent(n));
        pulse(60'h1 << n, 8);
      end
    end
    wr(pa(16), 32'hf, 1'b1);
    rd(pa(16), 32'h7);
    wr(pa(17), 32'h2, 1'b1);
    q_tk.push_back(ent(17));
    q_tk.push_back(ent(16));
    q_tk.push_back(ent(18));
    q_tk.push_back(ent(19));
    pulse(60'h3 << 16, 20);
    pulse(60'h3 << 18, 20);
    wr(pa(20), 32'h4, 1'b1);
    wr(pa(21), 32'h4, 1'b1);
    wr(pa(22), 32'h1, 1'b1);
    hold <= 8'h28;
    q_tk.push_back(ent(20));
    q_tk.push_back(ent(22));
    q_tk.push_back(ent(2));
    q_tk.push_back(ent(3));
    q_tk.push_back(ent(20));
    q_tk.push_back(ent(21));
    pulse(60'h1 << 20, 5);
    pulse(60'h3 << 20, 3);
    pulse(60'h1 << 22, 5);
    pulse(60'hc, 30);
    // While the non-maskable handler runs, a software re-pend merges.
    wr(exv_pkg::REG_PSET_LO, 32'h0020_0000, 1'b1);
    rd(exv_pkg::REG_ACT_LO, 32'h0050_0004);
    rd(exv_pkg::REG_PEND_LO, 32'h0030_0008);
    rd(exv_pkg::REG_RUN, 32'h0000_0431);
    rd(exv_pkg::REG_EVT_STAT, 32'h2);
    repeat (360) @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(exv_pkg::REG_VTOR, 32'h0);
    rd(pa(17), 32'h0);
    repeat (2) @(posedge clk_i);
    chk(q_tk.size(), 0);
    end_of_test();
  end
endmodule : test_exception_vector_priority

`default_nettype wire
